// ### logic/rct_pkg.sv
// constants, field layout and state record of the rtc / compare timer
// assumes a 50 MHz pclk and a 32.768 kHz-class subclock on a pin
package rct_pkg;

  // ****************************************
  // register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [9:0] IDX_SEC = 10'h118;
  localparam logic [9:0] IDX_MIN = 10'h119;
  localparam logic [9:0] IDX_HR = 10'h11a;
  localparam logic [9:0] IDX_WK = 10'h11b;
  localparam logic [9:0] IDX_CR1 = 10'h11c;
  localparam logic [9:0] IDX_CR2 = 10'h11d;
  localparam logic [9:0] IDX_CSR = 10'h11e;

  // ****************************************
  // values after reset and write masks
  // ****************************************
  localparam logic [7:0] CR2_RST = 8'h00;
  localparam logic [7:0] CSR_RST = 8'h08;
  localparam logic [7:0] CSR_WMASK = 8'h6f;
  localparam logic [7:0] CR2_WMASK = 8'h3f;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CR1_STATUS = 1;
  localparam int CR1_OUTEN = 2;
  localparam int CR1_INT = 3;
  localparam int CR1_SRST = 4;
  localparam int CR1_PM = 5;
  localparam int CR1_H24 = 6;
  localparam int CR1_START = 7;
  localparam int CR2_SEC = 0;
  localparam int CR2_MIN = 1;
  localparam int CR2_HR = 2;
  localparam int CR2_DAY = 3;
  localparam int CR2_WK = 4;
  localparam int CR2_CMP = 5;
  localparam int CSR_NIB = 2;
  localparam int CSR_MODE = 3;

  // ****************************************
  // counting limits and cycle counts
  // ****************************************
  localparam logic [7:0] SEC_MAX = 8'h3b;
  localparam logic [7:0] MIN_MAX = 8'h3b;
  localparam logic [7:0] HR24_MAX = 8'h17;
  localparam logic [7:0] HR12_MAX = 8'h0b;
  localparam logic [7:0] WK_MAX = 8'h06;
  localparam logic [7:0] SUNDAY = 8'h00;
  localparam logic [1:0] FC4_LAST = 2'h3;
  localparam logic [3:0] NIB_LAST = 4'hf;
  localparam int unsigned SEC_TICKS_DEF = 8192;

  typedef enum logic [1:0] {
    RCT_SRC_F4 = 2'b00,
    RCT_SRC_F8 = 2'b01,
    RCT_SRC_F32 = 2'b10,
    RCT_SRC_FC4 = 2'b11
  } rct_src_e;

  typedef struct packed {
    logic o;
    logic oe;
  } rct_pin_s;

  typedef struct packed {
    logic [4:0] presc;
    logic sync1;
    logic sync2;
    logic sub_prev;
    logic [1:0] fc4_div;
    logic [15:0] rtc_div;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] wk;
    logic start;
    logic status;
    logic outen;
    logic int_bit;
    logic srst;
    logic pm;
    logic h24;
    logic [5:0] cr2;
    logic [7:0] csr;
    logic half;
    logic [3:0] cnt4;
    logic [7:0] cnt8;
    logic cmp_out;
    logic irq;
    rct_pin_s pin;
    logic [31:0] prdata;
  } rct_state_s;

  localparam rct_state_s ST_RST = '{csr: CSR_RST, default: '0};

endpackage

// ### logic/rct_timer.sv
// real-time clock / output compare timer with an apb register slave
// assumes a free pclk, a subclock on a pin and a port block for gpio use
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps

module rct_timer #(
  parameter int unsigned SEC_TICKS = rct_pkg::SEC_TICKS_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic subclk,
  input wire logic gpio_o,
  input wire logic gpio_oe,
  output rct_pkg::rct_pin_s pin,
  output logic timer_irq
);

  // ****************************************
  // state
  // ****************************************
  // all state lives in one record; the combinational block below fills st_next
  rct_pkg::rct_state_s st_reg;
  rct_pkg::rct_state_s st_next;

  // decode and event wires, all driven combinationally below
  logic setup;
  logic access;
  logic hit;
  logic wr;
  logic stopped;
  logic cmp_mode;
  logic t_f4;
  logic t_f8;
  logic t_f32;
  logic t_fc4;
  logic src_tick;
  logic run;
  logic step8;
  logic ev_sec;
  logic ev_min;
  logic ev_hr;
  logic ev_day;
  logic ev_wk;
  logic clk_sel;
  logic [7:0] hr_max;
  logic [7:0] rd;
  logic [7:0] wd;

  // ****************************************
  // apb handshake
  // ****************************************
  // read data is captured at the setup edge, so the access phase never waits
  // on the read mux; the price is that a read sees state one cycle old
  // zero wait state; pready drops with ce so no write is lost while frozen
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = ce;
  assign pslverr = access & ~hit;
  assign wr = access & pwrite & hit & pstrb[0] & ce;
  assign wd = pwdata[7:0];
  assign prdata = st_reg.prdata;
  assign pin = st_reg.pin;
  assign timer_irq = st_reg.irq;

  // address decode, register index sits in paddr[11:2]
  // paddr[1:0] is ignored, every register is one aligned word
  always_comb begin
    hit = 1'b0;
    unique case (paddr[11:2])
      rct_pkg::IDX_SEC,
      rct_pkg::IDX_MIN,
      rct_pkg::IDX_HR,
      rct_pkg::IDX_WK,
      rct_pkg::IDX_CR1,
      rct_pkg::IDX_CR2,
      rct_pkg::IDX_CSR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // read mux
  // ****************************************
  // compare mode reuses the seconds and minutes slots for counter and compare
  // value; reserved bits are forced to zero here and also in the stored copies on write
  always_comb begin
    rd = 8'h00;
    unique case (paddr[11:2])
      rct_pkg::IDX_SEC: begin
        rd = cmp_mode ? st_reg.cnt8 : st_reg.sec;
      end
      rct_pkg::IDX_MIN: rd = st_reg.min;
      rct_pkg::IDX_HR: rd = st_reg.hr;
      rct_pkg::IDX_WK: rd = st_reg.wk;
      rct_pkg::IDX_CR1: begin
        rd = {st_reg.start, st_reg.h24, st_reg.pm, st_reg.srst,
              st_reg.int_bit, st_reg.outen, st_reg.status, 1'b0};
      end
      rct_pkg::IDX_CR2: rd = {2'b00, st_reg.cr2};
      rct_pkg::IDX_CSR: rd = st_reg.csr & rct_pkg::CSR_WMASK;
      default: rd = 8'h00;
    endcase
  end

  // ****************************************
  // internal clock taps
  // ****************************************
  // f2..f32 are enables carved from one free prescaler, never real clocks
  // so the whole block stays on pclk and no clock crosses a domain
  assign t_f4 = (st_reg.presc[1:0] == 2'b11);
  assign t_f8 = (st_reg.presc[2:0] == 3'b111);
  assign t_f32 = (st_reg.presc == 5'h1f);
  // subclock edge seen on the synchronised copy only
  assign t_fc4 = st_reg.sync2 & ~st_reg.sub_prev & (st_reg.fc4_div == rct_pkg::FC4_LAST);
  assign cmp_mode = ~st_reg.csr[rct_pkg::CSR_MODE];
  assign stopped = ~st_reg.start & ~st_reg.status;
  assign hr_max = st_reg.h24 ? rct_pkg::HR24_MAX : rct_pkg::HR12_MAX;

  // count source select; the clock mode always runs from the subclock
  always_comb begin
    src_tick = t_fc4;
    if (cmp_mode) begin
      unique case (rct_pkg::rct_src_e'(st_reg.csr[1:0]))
        rct_pkg::RCT_SRC_F4: src_tick = t_f4;
        rct_pkg::RCT_SRC_F8: src_tick = t_f8;
        rct_pkg::RCT_SRC_F32: src_tick = t_f32;
        rct_pkg::RCT_SRC_FC4: src_tick = t_fc4;
      endcase
    end
  end

  // counting is gated by the status flag, not by the start bit itself
  assign run = st_reg.status & src_tick;

  // divided clock for the pin, select 11 falls back to f8
  // the pin copy adds one cycle, so its edges lag the prescaler by one
  always_comb begin
    unique case (st_reg.csr[6:5])
      2'b00: clk_sel = st_reg.presc[0];
      2'b01: clk_sel = st_reg.presc[1];
      default: clk_sel = st_reg.presc[2];
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    ev_sec = 1'b0;
    ev_min = 1'b0;
    ev_hr = 1'b0;
    ev_day = 1'b0;
    ev_wk = 1'b0;
    step8 = 1'b0;
    st_next.irq = 1'b0;

    // prescaler and two-flop subclock synchroniser
    st_next.presc = st_reg.presc + 5'h01;
    st_next.sync1 = subclk;
    st_next.sync2 = st_reg.sync1;
    st_next.sub_prev = st_reg.sync2;
    if (st_reg.sync2 & ~st_reg.sub_prev) begin
      st_next.fc4_div = st_reg.fc4_div + 2'h1;
    end

    // status follows start on the next source tick, well inside two
    // a slow source such as f32 makes this wait up to 32 pclk cycles
    if (src_tick) begin
      st_next.status = st_reg.start;
    end

    // clock mode: second prescaler, then the calendar chain
    // values written out of range wrap at the next update, never stick
    if (!cmp_mode && run) begin
      if (st_reg.rtc_div == 16'(SEC_TICKS - 1)) begin
        st_next.rtc_div = 16'h0000;
        ev_sec = 1'b1;
      end else begin
        st_next.rtc_div = st_reg.rtc_div + 16'h0001;
      end
    end
    if (ev_sec) begin
      if (st_reg.sec >= rct_pkg::SEC_MAX) begin
        st_next.sec = 8'h00;
        ev_min = 1'b1;
      end else begin
        st_next.sec = st_reg.sec + 8'h01;
      end
    end
    if (ev_min) begin
      if (st_reg.min >= rct_pkg::MIN_MAX) begin
        st_next.min = 8'h00;
        ev_hr = 1'b1;
      end else begin
        st_next.min = st_reg.min + 8'h01;
      end
    end
    if (ev_hr) begin
      if (st_reg.hr >= hr_max) begin
        st_next.hr = 8'h00;
        // twelve-hour mode: the day turns when p.m. goes back to a.m.
        // in 24-hour mode pm stays low and every wrap is a new day
        st_next.pm = ~st_reg.pm & ~st_reg.h24;
        ev_day = st_reg.h24 | st_reg.pm;
      end else begin
        st_next.hr = st_reg.hr + 8'h01;
      end
    end
    if (ev_day) begin
      if (st_reg.wk >= rct_pkg::WK_MAX) begin
        st_next.wk = rct_pkg::SUNDAY;
        ev_wk = 1'b1;
      end else begin
        st_next.wk = st_reg.wk + 8'h01;
      end
    end

    // periodic interrupt request, one pclk pulse per event
    // several events at one rollover still make one pulse, not a burst
    if (!cmp_mode) begin
      st_next.irq = (ev_sec & st_reg.cr2[rct_pkg::CR2_SEC])
                  | (ev_min & st_reg.cr2[rct_pkg::CR2_MIN])
                  | (ev_hr & st_reg.cr2[rct_pkg::CR2_HR])
                  | (ev_day & st_reg.cr2[rct_pkg::CR2_DAY])
                  | (ev_wk & st_reg.cr2[rct_pkg::CR2_WK]);
    end

    // compare mode: halve the source, optional nibble, then byte counter
    // nothing here runs while stopped, so counts and pin level hold
    // the half flop keeps its phase too, so a restart resumes mid-period
    if (cmp_mode && run) begin
      st_next.half = ~st_reg.half;
      if (st_reg.half) begin
        if (st_reg.csr[rct_pkg::CSR_NIB]) begin
          st_next.cnt4 = st_reg.cnt4 + 4'h1;
          step8 = (st_reg.cnt4 == rct_pkg::NIB_LAST);
        end else begin
          step8 = 1'b1;
        end
      end
    end
    if (step8) begin
      if (st_reg.cnt8 == st_reg.min) begin
        // wrap, toggle and request share this one tick
        st_next.cnt8 = 8'h00;
        st_next.cmp_out = ~st_reg.cmp_out;
        st_next.irq = st_reg.cr2[rct_pkg::CR2_CMP];
      end else begin
        st_next.cnt8 = st_reg.cnt8 + 8'h01;
      end
    end

    // read data is latched in the setup phase
    // an unmapped access returns zero together with its error response
    if (setup) begin
      st_next.prdata = {24'h00_0000, rd};
    end else if (access && !hit) begin
      st_next.prdata = 32'h0000_0000;
    end

    // register writes land at the access edge
    // writing time or control while running is software's hazard; only the
    // compare value and the compare-mode counter are guarded in hardware
    if (wr) begin
      unique case (paddr[11:2])
        rct_pkg::IDX_SEC: begin
          if (!cmp_mode) begin
            st_next.sec = wd;
          end
        end
        rct_pkg::IDX_MIN: begin
          if (!cmp_mode || stopped) begin
            st_next.min = wd;
          end
        end
        rct_pkg::IDX_HR: st_next.hr = wd;
        rct_pkg::IDX_WK: st_next.wk = wd;
        rct_pkg::IDX_CR1: begin
          st_next.start = wd[rct_pkg::CR1_START];
          st_next.h24 = wd[rct_pkg::CR1_H24];
          st_next.pm = wd[rct_pkg::CR1_PM];
          st_next.srst = wd[rct_pkg::CR1_SRST];
          st_next.int_bit = wd[rct_pkg::CR1_INT];
          st_next.outen = wd[rct_pkg::CR1_OUTEN];
        end
        rct_pkg::IDX_CR2: st_next.cr2 = wd[5:0] & rct_pkg::CR2_WMASK[5:0];
        rct_pkg::IDX_CSR: st_next.csr = wd & rct_pkg::CSR_WMASK;
        default: st_next.csr = st_reg.csr;
      endcase

      // soft reset acts on the write that takes the bit from 1 to 0
      // the source select and the output enable survive it on purpose
      if (paddr[11:2] == rct_pkg::IDX_CR1 && st_reg.srst && !wd[rct_pkg::CR1_SRST]) begin
        st_next.sec = 8'h00;
        st_next.min = 8'h00;
        st_next.hr = 8'h00;
        st_next.wk = 8'h00;
        st_next.cr2 = rct_pkg::CR2_RST[5:0];
        st_next.status = 1'b0;
        st_next.int_bit = 1'b0;
        st_next.pm = 1'b0;
        st_next.h24 = 1'b0;
        st_next.start = 1'b0;
        st_next.cnt8 = 8'h00;
        st_next.cnt4 = 4'h0;
        st_next.half = 1'b0;
        st_next.rtc_div = 16'h0000;
        st_next.cmp_out = 1'b0;
        st_next.irq = 1'b0;
      end
    end

    // pin function: divided clock, compare level or the port's own drive
    // one flop on every path keeps the pin free of decode glitches
    if (st_reg.outen) begin
      st_next.pin.oe = 1'b1;
      st_next.pin.o = cmp_mode ? st_reg.cmp_out : clk_sel;
    end else begin
      st_next.pin.oe = gpio_oe;
      st_next.pin.o = gpio_o;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // ce low freezes every flop, prescaler and synchroniser included
  // a frozen synchroniser may miss subclock edges; ce is meant for a debug halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= rct_pkg::ST_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

endmodule

// ### verification/rct_timer_asserts.sv
// port checker for the rtc / compare timer
// assumes binding into rct_timer; apb writes are shadowed to learn the mode
`timescale 1ns/1ps
module rct_timer_asserts #(
  parameter int unsigned SEC_TICKS = rct_pkg::SEC_TICKS_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic subclk,
  input wire logic gpio_o,
  input wire logic gpio_oe,
  input wire rct_pkg::rct_pin_s pin,
  input wire logic timer_irq
);
  // ****
  // shadow of mode and output enable
  // ****
  logic mode_q;
  logic outen_q;
  logic wr;
  // soft reset keeps both bits, so only plain writes move them
  assign wr = psel && penable && pwrite && ce && pstrb[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b1;
      outen_q <= 1'b0;
    end else if (wr && paddr[11:2] == rct_pkg::IDX_CSR) begin
      mode_q <= pwdata[rct_pkg::CSR_MODE];
    end else if (wr && paddr[11:2] == rct_pkg::IDX_CR1) begin
      outen_q <= pwdata[rct_pkg::CR1_OUTEN];
    end
  end

  // ****
  // properties
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_ce: assert property (pready == ce) else $error("pready differs from ce");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("error outside access");
  a_err_map: assert property (psel && penable |->
    pslverr == !(paddr[11:2] inside {[rct_pkg::IDX_SEC:rct_pkg::IDX_CSR]})) else $error("bad error flag");
  a_rdata_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_reserved_zero: assert property (psel && penable && !pwrite |->
    !(paddr[11:2] == rct_pkg::IDX_CSR && (prdata[7] || prdata[4])) &&
    !(paddr[11:2] == rct_pkg::IDX_CR2 && prdata[7:6] != 2'b00)) else $error("reserved bit reads one");
  a_irq_pulse: assert property (timer_irq && ce |=> !timer_irq) else $error("irq longer than one cycle");
  a_gpio_pass: assert property (!outen_q && ce |=> pin.o == $past(gpio_o) && pin.oe == $past(gpio_oe))
    else $error("pin does not follow port");
  a_cmp_toggle: assert property (timer_irq && ce && !mode_q && outen_q |=> pin.o != $past(pin.o))
    else $error("no toggle on match");
  a_ce_freeze: assert property (!ce |=> $stable(pin) && $stable(timer_irq) && $stable(prdata))
    else $error("outputs moved while ce low");
  a_reset_low: assert property ($rose(presetn) |-> !pin.o) else $error("pin high after reset");
endmodule

bind rct_timer rct_timer_asserts #(.SEC_TICKS(SEC_TICKS)) u_rct_timer_asserts (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .subclk(subclk), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .pin(pin),
  .timer_irq(timer_irq)
);

// ### verification/tb_rct_timer.sv
// self-checking apb bench for the rtc / compare timer
// assumes the package and the bound checker are compiled before it
`timescale 1ns/1ps
module tb_rct_timer;
  localparam int SEC_N = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic subclk = 1'b0;
  logic gpio_o = 1'b0;
  logic gpio_oe = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rct_pkg::rct_pin_s pin;
  logic timer_irq;
  logic [31:0] q;
  logic e;
  logic o_keep;
  int t;
  int n_tog;
  int fails = 0;
  int comparisons = 0;
  // f4, f8, f32, fc4 in pclk cycles; last entry is f4 through the nibble counter
  int per[5] = '{4, 8, 32, 32, 64};

  // subclock runs at an eighth of pclk, so fc4 ticks every 32 cycles
  always #10 pclk = ~pclk;
  always #80 subclk = ~subclk;

  rct_timer #(.SEC_TICKS(SEC_N)) u_rct_timer (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subclk(subclk), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .pin(pin),
    .timer_irq(timer_irq)
  );

  // ****
  // tasks
  // ****
  task automatic results();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [9:0] x, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {x, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      fails++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] x, input logic [7:0] d);
    apb(1'b1, x, d);
  endtask

  task automatic rd(input logic [9:0] x, input logic [7:0] d);
    apb(1'b0, x, 8'h00);
    chk(q, {24'h00_0000, d});
  endtask

  // cycles until the next irq pulse; a must-wait that runs out ends the run
  task automatic wait_irq(input int lim, input logic must);
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (timer_irq !== 1'b1 && t < lim);
    if (must && timer_irq !== 1'b1) begin
      fails++;
      results();
    end
  endtask

  // ****
  // sequence
  // ****
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    gpio_o <= 1'b1;
    gpio_oe <= 1'b1;
    rd(rct_pkg::IDX_CR2, 8'h00);
    rd(rct_pkg::IDX_CSR, 8'h08);
    apb(1'b0, 10'h11f, 8'h00);
    chk({31'h0, e}, 32'h0000_0001);
    wr(rct_pkg::IDX_CSR, 8'hbf);
    rd(rct_pkg::IDX_CSR, 8'h2f);
    wr(rct_pkg::IDX_CR2, 8'hff);
    rd(rct_pkg::IDX_CR2, 8'h3f);
    // compare mode with compare value 3 and the compare irq on
    wr(rct_pkg::IDX_CR2, 8'h20);
    wr(rct_pkg::IDX_CSR, 8'h00);
    wr(rct_pkg::IDX_MIN, 8'h03);
    wr(rct_pkg::IDX_SEC, 8'h55);
    rd(rct_pkg::IDX_SEC, 8'h00);
    rd(rct_pkg::IDX_MIN, 8'h03);
    for (int s = 0; s < 5; s++) begin
      wr(rct_pkg::IDX_CSR, (s == 4) ? 8'h04 : 8'(s));
      wr(rct_pkg::IDX_CR1, 8'h84);
      wait_irq(3000, 1'b1);
      wr(rct_pkg::IDX_MIN, 8'h09);
      wait_irq(3000, 1'b1);
      wait_irq(3000, 1'b1);
      chk(t, 8 * per[s]);
      rd(rct_pkg::IDX_CR1, 8'h86);
      wr(rct_pkg::IDX_CR1, 8'h04);
      repeat (100) @(posedge pclk);
      rd(rct_pkg::IDX_CR1, 8'h04);
    end
    o_keep = pin.o;
    // three matches in each of five runs leave an odd number of toggles
    chk({31'h0, o_keep}, 32'h0000_0001);
    apb(1'b0, rct_pkg::IDX_SEC, 8'h00);
    repeat (200) @(posedge pclk);
    rd(rct_pkg::IDX_SEC, q[7:0]);
    chk({31'h0, pin.o}, {31'h0, o_keep});
    // soft reset: bit set, then cleared
    wr(rct_pkg::IDX_CR1, 8'h14);
    wr(rct_pkg::IDX_CR1, 8'h04);
    repeat (3) @(posedge pclk);
    chk({31'h0, pin.o}, 32'h0000_0000);
    rd(rct_pkg::IDX_MIN, 8'h00);
    rd(rct_pkg::IDX_CR2, 8'h00);
    rd(rct_pkg::IDX_CR1, 8'h04);
    // clock mode, 24 hour, each periodic enable alone at a full rollover, then the week enable alone with no week wrap
    wr(rct_pkg::IDX_CSR, 8'h08);
    wr(rct_pkg::IDX_CR1, 8'h40);
    for (int k = 0; k < 6; k++) begin
      gpio_o <= k[0];
      wr(rct_pkg::IDX_CR2, (k == 5) ? 8'h10 : 8'(1 << k));
      wr(rct_pkg::IDX_SEC, 8'h3b);
      wr(rct_pkg::IDX_MIN, 8'h3b);
      wr(rct_pkg::IDX_HR, 8'h17);
      wr(rct_pkg::IDX_WK, (k == 5) ? 8'h02 : 8'h06);
      wr(rct_pkg::IDX_CR1, 8'hc0);
      wait_irq(400, k < 5);
      if (k == 0) begin
        wait_irq(400, 1'b1);
        chk(t, SEC_N * 32);
      end
      if (k == 5) chk(t, 400);
      rd(rct_pkg::IDX_WK, (k == 5) ? 8'h03 : 8'h00);
      wr(rct_pkg::IDX_CR1, 8'h40);
      repeat (100) @(posedge pclk);
    end
    // divided clock on the pin: f2, f4, f8 change 16, 8, 4 times in 16 cycles; ce low freezes it
    wr(rct_pkg::IDX_CR1, 8'h44);
    for (int c = 0; c < 4; c++) begin
      wr(rct_pkg::IDX_CSR, 8'h08 | (8'(c % 3) << 5));
      ce <= (c < 3);
      repeat (2) @(posedge pclk);
      o_keep = pin.o;
      n_tog = 0;
      repeat (16) begin
        @(posedge pclk);
        if (pin.o !== o_keep) n_tog++;
        o_keep = pin.o;
      end
      ce <= 1'b1;
      chk(n_tog, (c == 3) ? 0 : 16 >> c);
      chk({31'h0, pin.oe}, 32'h0000_0001);
    end
    results();
  end
endmodule
